// ===== zdf_map.svh
`ifndef ZDF_MAP_SVH
`define ZDF_MAP_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define ZDF_ADDR_CFG      8'hdb
`define ZDF_ADDR_STAT     8'hdc

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define ZDF_WEIGHT_MSB    3
`define ZDF_WEIGHT_LSB    0
`define ZDF_FLAG_BIT      3

// ----------------------------------------------------------------
// reset values and counts
// ----------------------------------------------------------------
`define ZDF_WEIGHT_RST    4'h0
`define ZDF_COUNT_RST     4'h0
`define ZDF_COUNT_TRIP    4'hf
`define ZDF_COUNT_DEC     4'h1
`define ZDF_SAMPLE_ZERO   14'h0000
`define ZDF_RDATA_RST     8'h00

`endif

// ===== zdf_pkg.sv
package zdf_pkg;
    typedef logic [3:0]  zdf_weight_t;
    typedef logic [3:0]  zdf_count_t;
    typedef logic [13:0] zdf_sample_t;
    typedef logic [7:0]  zdf_reg_t;
endpackage

// ===== zdf_counter.sv
`include "zdf_map.svh"

module zdf_counter (
    // clock and reset
    input  wire logic                clock,
    input  wire logic                resetn,
    // measurement cycle
    input  wire logic                step,
    input  wire logic                zero_seen,
    input  wire zdf_pkg::zdf_weight_t weight,
    // state
    output zdf_pkg::zdf_count_t      count,
    output logic                     hit
);
    import zdf_pkg::*;

    // ----------------------------------------------------------------
    // saturating zero-tracking counter
    // ----------------------------------------------------------------
    logic [4:0] sum;
    zdf_count_t next_count;

    assign sum = {1'b0, count} + {1'b0, weight};

    always_comb begin
        next_count = count;
        if (step) begin
            if (zero_seen) begin
                next_count = (sum > {1'b0, `ZDF_COUNT_TRIP}) ? `ZDF_COUNT_TRIP : sum[3:0];
            end else if (count != `ZDF_COUNT_RST) begin
                next_count = count - `ZDF_COUNT_DEC;
            end
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            count <= `ZDF_COUNT_RST;
        end else begin
            count <= next_count;
        end
    end

    // a zero weight can never trip, even when a stale count sits at the top
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            hit <= 1'b0;
        end else begin
            hit <= step && zero_seen && (weight != `ZDF_WEIGHT_RST) &&
                   (next_count == `ZDF_COUNT_TRIP);
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    AST_CNT_DEC: assert property (@(posedge clock) disable iff (!resetn)
        step && !zero_seen && count != 4'h0 |=> count == $past(count) - 4'h1)
        else $error("counter did not drop by one");

    AST_CNT_FLOOR: assert property (@(posedge clock) disable iff (!resetn)
        step && !zero_seen && count == 4'h0 |=> count == 4'h0)
        else $error("counter went below zero");

    AST_CNT_SAT: assert property (@(posedge clock) disable iff (!resetn)
        step && zero_seen && sum > 5'h0f |=> count == 4'hf)
        else $error("counter wrapped instead of saturating");

    AST_W0_NOHIT: assert property (@(posedge clock) disable iff (!resetn)
        weight == 4'h0 |=> !hit)
        else $error("trip with zero weight");
endmodule

// ===== zdf_filter.sv
// Functional notes
// - flag sets once zero-tracking counter reaches fifteen
// - any zero among four channel results adds weight to counter
// - a measurement cycle without zeros lowers counter by one
// - weight field bits 3:0 is the increment; zero disables detection
// - flag is status bit 3, raises interrupt when irq enable set
// - flag holds until software writes one to its bit
`include "zdf_map.svh"

module zdf_filter (
    // clock and reset
    input  wire logic                 clock,
    input  wire logic                 resetn,
    // measurement path
    input  wire logic                 meas_valid,
    input  wire logic                 meas_active,
    input  wire zdf_pkg::zdf_sample_t ch_data_0,
    input  wire zdf_pkg::zdf_sample_t ch_data_1,
    input  wire zdf_pkg::zdf_sample_t ch_data_2,
    input  wire zdf_pkg::zdf_sample_t ch_data_3,
    // register port
    input  wire zdf_pkg::zdf_reg_t    reg_addr,
    input  wire logic                 reg_wr,
    input  wire zdf_pkg::zdf_reg_t    reg_wdata,
    input  wire logic                 reg_rd,
    output zdf_pkg::zdf_reg_t         reg_rdata,
    output logic                      reg_rvalid,
    // interrupt control
    input  wire logic                 calib_irq_enable,
    output logic                      zero_detected,
    output logic                      calib_irq
);
    import zdf_pkg::*;

    // ----------------------------------------------------------------
    // per-channel zero detect
    // ----------------------------------------------------------------
    zdf_sample_t ch_data [4];
    logic [3:0]  ch_zero;
    logic        any_zero;
    logic        step;

    assign ch_data[0] = ch_data_0;
    assign ch_data[1] = ch_data_1;
    assign ch_data[2] = ch_data_2;
    assign ch_data[3] = ch_data_3;

    for (genvar i = 0; i < 4; i++) begin : g_zero
        assign ch_zero[i] = (ch_data[i] == `ZDF_SAMPLE_ZERO);
    end

    assign any_zero = |ch_zero;
    // only normal proximity/gesture cycles feed the counter
    assign step     = meas_valid && meas_active;

    // ----------------------------------------------------------------
    // configuration register
    // ----------------------------------------------------------------
    zdf_weight_t weight;
    logic        cfg_wr;
    logic        stat_wr;
    logic        flag_clr;

    assign cfg_wr   = reg_wr && (reg_addr == `ZDF_ADDR_CFG);
    assign stat_wr  = reg_wr && (reg_addr == `ZDF_ADDR_STAT);
    assign flag_clr = stat_wr && reg_wdata[`ZDF_FLAG_BIT];

    // weight is used as written; no check against the offset fix modes
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            weight <= `ZDF_WEIGHT_RST;
        end else if (cfg_wr) begin
            weight <= reg_wdata[`ZDF_WEIGHT_MSB:`ZDF_WEIGHT_LSB];
        end
    end

    // ----------------------------------------------------------------
    // zero-tracking counter
    // ----------------------------------------------------------------
    zdf_count_t count;
    logic       hit;

    zdf_counter u_counter (
        .clock     (clock),
        .resetn    (resetn),
        .step      (step),
        .zero_seen (any_zero),
        .weight    (weight),
        .count     (count),
        .hit       (hit)
    );

    // ----------------------------------------------------------------
    // status flag
    // ----------------------------------------------------------------
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            zero_detected <= 1'b0;
        end else if (hit) begin
            zero_detected <= 1'b1;
        end else if (flag_clr) begin
            zero_detected <= 1'b0;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            calib_irq <= 1'b0;
        end else begin
            calib_irq <= zero_detected && calib_irq_enable;
        end
    end

    // ----------------------------------------------------------------
    // read path
    // ----------------------------------------------------------------
    zdf_reg_t next_rdata;

    always_comb begin
        next_rdata = `ZDF_RDATA_RST;
        case (reg_addr)
            `ZDF_ADDR_CFG: begin
                next_rdata[`ZDF_WEIGHT_MSB:`ZDF_WEIGHT_LSB] = weight;
            end
            `ZDF_ADDR_STAT: begin
                next_rdata[`ZDF_FLAG_BIT] = zero_detected;
            end
            default: begin
                next_rdata = `ZDF_RDATA_RST;
            end
        endcase
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            reg_rdata <= `ZDF_RDATA_RST;
        end else if (reg_rd) begin
            reg_rdata <= next_rdata;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    logic [4:0] chk_sum;

    assign chk_sum = {1'b0, count} + {1'b0, weight};

    sequence seq_trip_cycle;
        step && any_zero && (weight != 4'h0) && (chk_sum >= 5'h0f);
    endsequence

    sequence seq_hit_then_flag;
        hit ##1 zero_detected;
    endsequence

    sequence seq_zero_add;
        step && any_zero && (chk_sum < 5'h0f);
    endsequence

    AST_TRIP_FLAG: assert property (@(posedge clock) disable iff (!resetn)
        seq_trip_cycle |=> seq_hit_then_flag)
        else $error("flag not set two cycles after counter reached fifteen");

    AST_ZERO_ADD: assert property (@(posedge clock) disable iff (!resetn)
        seq_zero_add |=> count == $past(chk_sum[3:0]))
        else $error("zero cycle did not add the weight");

    AST_NO_STEP_HOLD: assert property (@(posedge clock) disable iff (!resetn)
        !step |=> $stable(count))
        else $error("counter moved outside a measurement cycle");

    AST_FLAG_HOLD: assert property (@(posedge clock) disable iff (!resetn)
        zero_detected && !flag_clr |=> zero_detected)
        else $error("flag dropped without a clear");

    AST_FLAG_CLEAR: assert property (@(posedge clock) disable iff (!resetn)
        flag_clr && !hit |=> !zero_detected)
        else $error("write one did not clear the flag");

    AST_FLAG_CAUSE: assert property (@(posedge clock) disable iff (!resetn)
        $rose(zero_detected) |-> $past(hit))
        else $error("flag rose without a trip");

    AST_IRQ_GATE: assert property (@(posedge clock) disable iff (!resetn)
        zero_detected && calib_irq_enable |=> calib_irq)
        else $error("interrupt missing while flag and enable set");

    AST_IRQ_MASK: assert property (@(posedge clock) disable iff (!resetn)
        !calib_irq_enable |=> !calib_irq)
        else $error("interrupt raised while disabled");

    AST_STAT_READ: assert property (@(posedge clock) disable iff (!resetn)
        reg_rd && reg_addr == 8'hdc |=> reg_rvalid && reg_rdata == {4'h0, $past(zero_detected), 3'h0})
        else $error("status read does not show the flag at bit three");

    AST_CFG_WRITE: assert property (@(posedge clock) disable iff (!resetn)
        cfg_wr |=> weight == $past(reg_wdata[3:0]))
        else $error("weight field not stored");

    // a write in the read cycle must not leak into the answer
    AST_CFG_READ: assert property (@(posedge clock) disable iff (!resetn)
        reg_rd && reg_addr == 8'hdb |=> reg_rdata == {4'h0, $past(weight)})
        else $error("weight read back wrong");

    AST_IRQ_DROP: assert property (@(posedge clock) disable iff (!resetn)
        !zero_detected |=> !calib_irq)
        else $error("interrupt raised without the flag");

    AST_RD_VALID: assert property (@(posedge clock) disable iff (!resetn)
        reg_rd |=> reg_rvalid)
        else $error("read answer missing");
endmodule

// ===== zdf_host.sv
module zdf_host (
    // clock
    input  wire logic              clock,
    // register port
    output zdf_pkg::zdf_reg_t      reg_addr,
    output logic                   reg_wr,
    output zdf_pkg::zdf_reg_t      reg_wdata,
    output logic                   reg_rd,
    input  wire zdf_pkg::zdf_reg_t reg_rdata,
    input  wire logic              reg_rvalid
);
    timeunit 1ns;
    timeprecision 1ps;
    import zdf_pkg::*;

    initial begin
        reg_addr  = 8'h00;
        reg_wr    = 1'b0;
        reg_wdata = 8'h00;
        reg_rd    = 1'b0;
    end

    // offset fixes
    // automatic offset fixes assumed off, so any weight is legal here
    // one clears
    task automatic wr(input zdf_reg_t a, input zdf_reg_t d);
        @(posedge clock);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clock);
        reg_wr    <= 1'b0;
        // released data never keeps the stale value
        reg_wdata <= ~d;
        reg_addr  <= ~a;
    endtask

    task automatic rd(input zdf_reg_t a, output zdf_reg_t d, output logic v);
        @(posedge clock);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clock);
        reg_rd   <= 1'b0;
        reg_addr <= ~a;
        @(negedge clock);
        d = reg_rdata;
        v = reg_rvalid;
    endtask
endmodule

// ===== testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import zdf_pkg::*;

    logic        clock = 1'b0;
    logic        resetn = 1'b0;
    logic        meas_valid = 1'b0;
    logic        meas_active = 1'b0;
    logic        calib_irq_enable = 1'b0;
    zdf_sample_t ch [4] = '{default: 14'h0001};
    zdf_reg_t    reg_addr, reg_wdata, reg_rdata, rdv;
    logic        reg_wr, reg_rd, reg_rvalid, zero_detected, calib_irq, vld;
    int          n_fail = 0;
    int          compares = 0;
    int          m_count = 0;
    int          m_weight = 0;
    bit          m_flag = 0;

    always #2 clock = ~clock;

    zdf_host host_u (.clock(clock), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid));

    zdf_filter dut_u (.clock(clock), .resetn(resetn), .meas_valid(meas_valid),
        .meas_active(meas_active), .ch_data_0(ch[0]), .ch_data_1(ch[1]),
        .ch_data_2(ch[2]), .ch_data_3(ch[3]), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .calib_irq_enable(calib_irq_enable), .zero_detected(zero_detected),
        .calib_irq(calib_irq));

    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic close_out();
        $display("compares=%0d n_fail=%0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic rd_check(input zdf_reg_t a, input zdf_reg_t exp);
        host_u.rd(a, rdv, vld);
        check(vld, 1'b1, "read valid");
        check(rdv, exp, "read data");
    endtask

    task automatic wr_model(input zdf_reg_t a, input zdf_reg_t d);
        host_u.wr(a, d);
        if (a == 8'hdb) begin
            m_weight = d[3:0];
        end
        if (a == 8'hdc && d[3]) begin
            m_flag = 0;
        end
    endtask

    // one measurement; zmask picks which channels read zero
    task automatic meas_step(input logic [3:0] zmask, input logic act, input logic en);
        @(posedge clock);
        meas_valid       <= 1'b1;
        meas_active      <= act;
        calib_irq_enable <= en;
        for (int i = 0; i < 4; i++) begin
            ch[i] <= zmask[i] ? 14'h0000 : zdf_sample_t'(1 + $urandom % 16383);
        end
        @(posedge clock);
        meas_valid <= 1'b0;
        if (act && zmask != 0 && m_weight != 0) begin
            m_count = (m_count + m_weight > 15) ? 15 : m_count + m_weight;
            m_flag  = m_flag | (m_count == 15);
        end else if (act && zmask == 0 && m_count > 0) begin
            m_count--;
        end
        repeat (3) @(posedge clock);
        @(negedge clock);
        check(zero_detected, m_flag, "zero flag");
        check(calib_irq, m_flag & en, "irq");
    endtask

    initial begin
        #200000;
        n_fail++;
        close_out();
    end

    initial begin
        void'($urandom(59));
        repeat (8) @(posedge clock);
        resetn <= 1'b1;
        rd_check(8'hdb, 8'h00);
        rd_check(8'hdc, 8'h00);
        rd_check(8'h5a, 8'h00);
        wr_model(8'hdb, 8'hff);
        rd_check(8'hdb, 8'h0f);
        $display("test reset and config done");
        wr_model(8'hdb, 8'h00);
        repeat (20) meas_step(4'hf, 1'b1, 1'b1);
        wr_model(8'hdb, 8'h0f);
        meas_step(4'b0100, 1'b0, 1'b1);
        meas_step(4'b0100, 1'b1, 1'b1);
        meas_step(4'b0000, 1'b1, 1'b1);
        rd_check(8'hdc, 8'h08);
        wr_model(8'hdc, 8'h00);
        rd_check(8'hdc, 8'h08);
        wr_model(8'hdc, 8'hff);
        rd_check(8'hdc, 8'h00);
        check(calib_irq, 1'b0, "irq after clear");
        // stale count at the top must not trip once the weight is zero
        meas_step(4'b0001, 1'b1, 1'b1);
        wr_model(8'hdc, 8'h08);
        wr_model(8'hdb, 8'h00);
        meas_step(4'b0010, 1'b1, 1'b1);
        $display("test flag and clear done");
        // random mix of config, clears and measurements
        for (int n = 0; n < 400; n++) begin
            case ($urandom % 16)
                0: wr_model(8'hdb, zdf_reg_t'($urandom));
                1: wr_model(8'hdc, 8'h08);
                2: rd_check(8'hdc, {4'h0, m_flag, 3'h0});
                default: meas_step(($urandom % 3 == 0) ? 4'($urandom) : 4'h0,
                                   $urandom % 8 != 0, 1'($urandom));
            endcase
        end
        $display("test random stream done");
        close_out();
    end
endmodule
